// ==== src/monitor_i2c_slave_regs.sv ====
// Two-wire slave front end and register map of the current and voltage monitor
`timescale 1ns/10ps
`default_nettype none
`include "mon_regs.svh"


module monitor_i2c_slave_regs
	import mon_pkg::*;
#(
	parameter int STUCK_CYCLES = `STUCK_MS * 1000 * `CLK_MHZ,
	parameter bit INVERT_OUT = 1'b0
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Three-level address straps
	input wire logic [1:0] addr_select_hi_pin,
	input wire logic [1:0] addr_select_lo_pin,
	// Converter results, ignored in test mode
	input wire logic meas_valid,
	input wire logic [11:0] meas_current,
	input wire logic [11:0] meas_voltage,
	input wire logic [11:0] meas_aux,
	// Mode bits towards the converter
	output logic [7:0] mode_control_o,
	// Link
	twi_if.device bus
);

	logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
	logic [3:0] strap_meta, strap_s;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [31:0] stuck_reg;
	logic stuck_expired;
	slave_state_t state_reg, after_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg, rd_byte;
	logic [2:0] ptr_reg;
	logic [1:0] nbytes_reg;
	logic sda_low_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] meas_hi_reg [3];
	logic [3:0] meas_lo_reg [3];
	logic own_match, page_ok, wr_now;

	// ==========================================
	// Helpers
	function automatic logic [3:0] strap_decode(input logic [1:0] hi, input logic [1:0] lo);
		logic [3:0] code;
		code = 4'hF;
		if (hi == `LVL_HIGH && lo == `LVL_LOW) code = 4'h7;
		else if (hi == `LVL_OPEN && lo == `LVL_HIGH) code = 4'h8;
		else if (hi == `LVL_HIGH && lo == `LVL_HIGH) code = 4'h9;
		else if (hi == `LVL_OPEN && lo == `LVL_OPEN) code = 4'hA;
		else if (hi == `LVL_OPEN && lo == `LVL_LOW) code = 4'hB;
		else if (hi == `LVL_LOW && lo == `LVL_HIGH) code = 4'hC;
		else if (hi == `LVL_HIGH && lo == `LVL_OPEN) code = 4'hD;
		else if (hi == `LVL_LOW && lo == `LVL_OPEN) code = 4'hE;
		return code;
	endfunction

	function automatic logic [2:0] next_ptr(input logic [2:0] p);
		return (p >= `PTR_LAST) ? `PTR_CUR_HI : p + 3'h1;
	endfunction

	function automatic logic [7:0] read_reg(input logic [2:0] p);
		logic [7:0] v;
		v = 8'h00;
		if (p == `PTR_CTRL) v = ctrl_reg;
		else if (p == `PTR_RSVD) v = 8'h00;
		else if (p[0]) v = {meas_lo_reg[p[2:1]], 4'h0};
		else v = meas_hi_reg[p[2:1]];
		return v;
	endfunction

	// ==========================================
	// Input synchronisers and line events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d} <= 6'h3F;
			{strap_meta, strap_s} <= 8'h00;
		end else if (ce) begin
			{scl_d, scl_s, scl_meta} <= {scl_s, scl_meta, bus.scl};
			{sda_d, sda_s, sda_meta} <= {sda_s, sda_meta, bus.sda};
			{strap_s, strap_meta} <= {strap_meta, addr_select_hi_pin, addr_select_lo_pin};
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================
	// Stuck-bus timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stuck_reg <= 32'h0;
		end else if (ce) begin
			if (!ctrl_reg[`STUCK_EN_BIT] || (scl_s && sda_s))
				stuck_reg <= 32'h0;
			else if (stuck_reg != 32'(STUCK_CYCLES))
				stuck_reg <= stuck_reg + 32'h1;
		end
	end

	// Held while the line stays low so the engine restarts cleanly on release
	assign stuck_expired = (stuck_reg == 32'(STUCK_CYCLES));
	always_comb rd_byte = read_reg(ptr_reg);
	assign own_match = (shift_reg[7:1] == {`ADDR_TOP, strap_decode(strap_s[3:2], strap_s[1:0])})
		|| (shift_reg == {`BCAST_ADDR, 1'b0});
	assign page_ok = ctrl_reg[`PAGE_EN_BIT] || (nbytes_reg < 2'h2);
	assign wr_now = (state_reg == ST_WDATA) && scl_fall && (bit_reg == 4'h8) && page_ok
		&& !stuck_expired && !stop_det && !start_det;

	// ==========================================
	// Protocol engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			after_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= `PTR_CUR_HI;
			nbytes_reg <= 2'h0;
			sda_low_reg <= 1'b0;
		end else if (ce) begin
			if (stuck_expired || stop_det) begin
				state_reg <= ST_IDLE;
				ptr_reg <= `PTR_CUR_HI;
				sda_low_reg <= 1'b0;
			end else if (start_det) begin
				state_reg <= ST_ADDR;
				bit_reg <= 4'h0;
				nbytes_reg <= 2'h0;
				sda_low_reg <= 1'b0;
			end else begin
				case (state_reg)
					ST_ADDR, ST_CMD, ST_WDATA: begin
						if (scl_rise && bit_reg != 4'h8) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_reg <= bit_reg + 4'h1;
						end else if (scl_fall && bit_reg == 4'h8) begin
							bit_reg <= 4'h0;
							state_reg <= ST_ACK;
							sda_low_reg <= 1'b1;
							if (state_reg == ST_ADDR) begin
								if (!own_match) begin
									state_reg <= ST_IDLE;
									sda_low_reg <= 1'b0;
								end
								after_reg <= shift_reg[0] ? ST_RDATA : ST_CMD;
							end else if (state_reg == ST_CMD) begin
								ptr_reg <= shift_reg[2:0];
								after_reg <= ST_WDATA;
							end else if (page_ok) begin
								ptr_reg <= next_ptr(ptr_reg);
								nbytes_reg <= (nbytes_reg == 2'h3) ? 2'h3 : nbytes_reg + 2'h1;
								after_reg <= ST_WDATA;
							end else begin
								state_reg <= ST_IDLE;
								sda_low_reg <= 1'b0;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							state_reg <= after_reg;
							bit_reg <= 4'h0;
							if (after_reg == ST_RDATA) begin
								shift_reg <= rd_byte;
								sda_low_reg <= ~rd_byte[7];
								ptr_reg <= next_ptr(ptr_reg);
								nbytes_reg <= (nbytes_reg == 2'h3) ? 2'h3 : nbytes_reg + 2'h1;
							end else begin
								sda_low_reg <= 1'b0;
							end
						end
					end
					ST_RDATA: begin
						if (scl_fall) begin
							if (bit_reg == 4'h7) begin
								sda_low_reg <= 1'b0;
								state_reg <= ST_MACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_low_reg <= ~shift_reg[6];
								bit_reg <= bit_reg + 4'h1;
							end
						end
					end
					ST_MACK: begin
						if (scl_rise) begin
							// Nack or page limit: stay off the line until stop or start
							if (sda_s || !page_ok)
								state_reg <= ST_IDLE;
							else begin
								state_reg <= ST_ACK;
								after_reg <= ST_RDATA;
							end
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================
	// Register map
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET;
			for (int i = 0; i < 3; i++) begin
				meas_hi_reg[i] <= 8'h00;
				meas_lo_reg[i] <= 4'h0;
			end
		end else if (ce) begin
			if (wr_now) begin
				if (ptr_reg == `PTR_CTRL)
					ctrl_reg <= shift_reg & `CTRL_WMASK;
				else if (ptr_reg != `PTR_RSVD && ctrl_reg[`TEST_WE_BIT]) begin
					if (ptr_reg[0])
						meas_lo_reg[ptr_reg[2:1]] <= shift_reg[7:4];
					else
						meas_hi_reg[ptr_reg[2:1]] <= shift_reg;
				end
			end else if (meas_valid && !ctrl_reg[`TEST_WE_BIT]) begin
				meas_hi_reg[0] <= meas_current[11:4];
				meas_lo_reg[0] <= meas_current[3:0];
				meas_hi_reg[1] <= meas_voltage[11:4];
				meas_lo_reg[1] <= meas_voltage[3:0];
				meas_hi_reg[2] <= meas_aux[11:4];
				meas_lo_reg[2] <= meas_aux[3:0];
			end
		end
	end

	assign mode_control_o = ctrl_reg;

	// Inverted variant drives its pin high to pull the line
	assign bus.dev_sda_o = INVERT_OUT ? sda_low_reg : 1'b0;
	assign bus.dev_sda_oe = INVERT_OUT ? 1'b1 : sda_low_reg;

endmodule

`default_nettype wire

// ==== src/mon_regs.svh ====
// Constants shared by both ends of the monitor serial link
`ifndef MON_REGS_SVH
`define MON_REGS_SVH

// ==========================================
// Bus addressing
`define ADDR_TOP 3'h6
`define BCAST_ADDR 7'h66

// ==========================================
// Register pointer values
`define PTR_CUR_HI 3'h0
`define PTR_CUR_LO 3'h1
`define PTR_VOLT_HI 3'h2
`define PTR_VOLT_LO 3'h3
`define PTR_AUX_HI 3'h4
`define PTR_AUX_LO 3'h5
`define PTR_CTRL 3'h6
`define PTR_RSVD 3'h7
`define PTR_LAST 3'h6

// ==========================================
// Mode control fields and reset
`define STUCK_EN_BIT 2
`define PAGE_EN_BIT 3
`define TEST_WE_BIT 4
`define CTRL_RESET 8'h0C
`define CTRL_WMASK 8'hFC

// ==========================================
// Strap levels
`define LVL_LOW 2'h0
`define LVL_HIGH 2'h1
`define LVL_OPEN 2'h2

// ==========================================
// Timing
`define CLK_MHZ 100
`define STUCK_MS 33
`define SCL_QUARTER 250

// ==========================================
// Controller registers on APB
`define APB_CMD 12'h000
`define APB_STATUS 12'h004
`define CMD_OP_LSB 0
`define CMD_NACK_BIT 2
`define CMD_DATA_LSB 8
`define ST_BUSY_BIT 0
`define ST_NACK_BIT 1
`define ST_DATA_LSB 8

`endif

// ==== src/mon_pkg.sv ====
// Types shared by both ends of the monitor serial link
package mon_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK} slave_state_t;

	typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_t;

endpackage

// ==== src/twi_if.sv ====
// Two-wire link joining the controller and the monitor slave
`timescale 1ns/10ps
`default_nettype none

interface twi_if #(
	parameter bit INVERT_OUT = 1'b0
);
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups win unless someone drives low; inverted output pulls the line when high
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | (INVERT_OUT ? (dev_sda_oe & dev_sda_o) : (dev_sda_oe & ~dev_sda_o)));

	modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

`default_nettype wire

// ==== src/monitor_i2c_master.sv ====
// Two-wire bus controller driven by software over APB
`timescale 1ns/10ps
`default_nettype none
`include "mon_regs.svh"

module monitor_i2c_master
	import mon_pkg::*;
#(
	parameter int QUARTER = `SCL_QUARTER
) (
	// Clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	twi_if.host bus
);

	logic sda_meta, sda_s;
	logic busy_reg, nack_reg, ack_cmd_reg;
	logic scl_oe_reg, sda_oe_reg;
	op_t op_reg;
	logic [7:0] tx_reg, rx_reg;
	logic [3:0] bit_reg;
	logic [1:0] phase_reg;
	logic [15:0] tick_reg;
	logic tick, apb_fire, launch;

	assign bus.host_scl_oe = scl_oe_reg;
	assign bus.host_sda_oe = sda_oe_reg;
	assign tick = (tick_reg == 16'(QUARTER - 1));
	assign apb_fire = psel & penable & pready;
	assign launch = apb_fire & pwrite & (paddr == `APB_CMD) & ~busy_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_meta <= 1'b1;
			sda_s <= 1'b1;
		end else if (ce) begin
			sda_meta <= bus.sda;
			sda_s <= sda_meta;
		end
	end

	// ==========================================
	// APB: one wait-free access phase, answer prepared in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			pready <= psel & ~penable & ~pready;
			if (psel & ~penable) begin
				pslverr <= (paddr != `APB_CMD) && (paddr != `APB_STATUS);
				prdata <= 32'h0;
				if (!pwrite && paddr == `APB_STATUS) begin
					prdata[`ST_BUSY_BIT] <= busy_reg;
					prdata[`ST_NACK_BIT] <= nack_reg;
					prdata[`ST_DATA_LSB +: 8] <= rx_reg;
				end
			end
		end
	end

	// ==========================================
	// Bit engine: four quarter ticks per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			nack_reg <= 1'b0;
			ack_cmd_reg <= 1'b0;
			op_reg <= OP_START;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			bit_reg <= 4'h0;
			phase_reg <= 2'h0;
			tick_reg <= 16'h0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (ce) begin
			if (launch) begin
				busy_reg <= 1'b1;
				op_reg <= op_t'(pwdata[`CMD_OP_LSB +: 2]);
				ack_cmd_reg <= ~pwdata[`CMD_NACK_BIT];
				tx_reg <= pwdata[`CMD_DATA_LSB +: 8];
				bit_reg <= 4'h0;
				phase_reg <= 2'h0;
				tick_reg <= 16'h0;
			end else if (busy_reg) begin
				tick_reg <= tick ? 16'h0 : tick_reg + 16'h1;
				if (tick) begin
					phase_reg <= phase_reg + 2'h1;
					case (op_reg)
						// Start, also repeated start from scl low
						OP_START: begin
							case (phase_reg)
								2'h0: sda_oe_reg <= 1'b0;
								2'h1: scl_oe_reg <= 1'b0;
								2'h2: sda_oe_reg <= 1'b1;
								default: scl_oe_reg <= 1'b1;
							endcase
						end
						OP_STOP: begin
							case (phase_reg)
								2'h0: sda_oe_reg <= 1'b1;
								2'h1: scl_oe_reg <= 1'b0;
								2'h2: sda_oe_reg <= 1'b0;
								default: ;
							endcase
						end
						default: begin
							case (phase_reg)
								2'h0: begin
									if (op_reg == OP_WRITE)
										sda_oe_reg <= (bit_reg != 4'h8) & ~tx_reg[7];
									else
										sda_oe_reg <= (bit_reg == 4'h8) & ack_cmd_reg;
								end
								2'h1: scl_oe_reg <= 1'b0;
								2'h2: begin
									if (bit_reg == 4'h8 && op_reg == OP_WRITE)
										nack_reg <= sda_s;
									else if (bit_reg != 4'h8)
										rx_reg <= {rx_reg[6:0], sda_s};
								end
								default: begin
									scl_oe_reg <= 1'b1;
									tx_reg <= {tx_reg[6:0], 1'b0};
								end
							endcase
						end
					endcase
					if (phase_reg == 2'h3) begin
						if ((op_reg == OP_WRITE || op_reg == OP_READ) && bit_reg != 4'h8)
							bit_reg <= bit_reg + 4'h1;
						else
							busy_reg <= 1'b0;
					end
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== verification/mon_link_props.sv ====
// Wire-level checks on the two-wire link between controller and monitor
`timescale 1ns/10ps
`default_nettype none

module mon_link_props #(
	parameter int QUARTER = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ==========================================
	// Helpers
	// Pull term assumes the non-inverted output variant
	logic dev_pull;
	int pull_cnt;
	assign dev_pull = dev_sda_oe & ~dev_sda_o;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pull_cnt <= 0;
		else
			pull_cnt <= dev_pull ? pull_cnt + 1 : 0;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================
	// Assertions
	chk_reset_idle: assert property ($rose(presetn) |-> scl && sda)
		else $error("link not idle after reset");
	chk_out_polarity: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device output pulls with wrong polarity");
	chk_no_collision: assert property (scl |-> !(host_sda_oe && dev_pull))
		else $error("both ends drive data while clock high");
	chk_edge_by_host: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
		else $error("data moved under high clock without controller");
	chk_dev_moves_low: assert property ($changed(dev_pull) |-> !scl && !$past(scl))
		else $error("device changed data outside clock low");
	chk_ack_bound: assert property (pull_cnt <= (36 + 12) * QUARTER)
		else $error("device holds data low too long");
	chk_scl_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	chk_scl_low_len: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");

	cover_start: cover property ($fell(sda) && scl);
	cover_dev_ack: cover property (scl && dev_pull);
	cover_host_ack: cover property (scl && host_sda_oe && $rose(scl));
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench joining controller and monitor slave over the link
`timescale 1ns/10ps
`default_nettype none
`include "mon_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("FAIL %0t %h %h", $time, a, b); end end

module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic meas_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [11:0] cur = 12'h000, volt = 12'h000, aux = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic [1:0] hi_pin = 2'h0, lo_pin = 2'h0;
	logic [1:0] hi_tab [9] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
	logic [1:0] lo_tab [9] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
	logic [7:0] mode_o;
	logic [7:0] mem [8];
	logic [7:0] wbuf [8];
	logic [11:0] m [3];
	logic [15:0] rnd = 16'h510A;
	logic [31:0] st;
	logic [2:0] ptr;
	logic [6:0] own;
	logic ce = 1'b1;
	logic [9:0] frz;
	int error_cnt = 0;
	int n_tests = 0;

	twi_if #(.INVERT_OUT(1'b0)) link ();
	monitor_i2c_master #(.QUARTER(4)) u_monitor_i2c_master (.pclk(pclk), .presetn(presetn), .ce(ce),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(link.host));
	// Stuck limit stays above three zero bytes in a row so normal traffic never trips it
	monitor_i2c_slave_regs #(.STUCK_CYCLES(600), .INVERT_OUT(1'b0)) u_monitor_i2c_slave_regs (.pclk(pclk),
		.presetn(presetn), .ce(ce), .addr_select_hi_pin(hi_pin), .addr_select_lo_pin(lo_pin),
		.meas_valid(meas_valid), .meas_current(cur), .meas_voltage(volt), .meas_aux(aux),
		.mode_control_o(mode_o), .bus(link.device));
	mon_link_props #(.QUARTER(4)) u_mon_link_props (.pclk(pclk), .presetn(presetn),
		.host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

	always #5 pclk = ~pclk;

	// ==========================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic close_out();
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		tick(6);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			mem[i] = 8'h00;
		mem[6] = `CTRL_RESET;
		ptr = 3'h0;
		tick(6);
	endtask

	// Idle edge after each transfer keeps psel from being assigned twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20) begin
			error_cnt++;
			close_out();
		end
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic op(input logic [1:0] c, input logic [7:0] b, input logic n);
		apb(1'b1, `APB_CMD, {16'h0, b, 5'h0, n, c}, st);
		wait_idle();
	endtask

	task automatic wait_idle();
		int k;
		for (k = 0; k < 100; k++) begin
			apb(1'b0, `APB_STATUS, 32'h0, st);
			if (st[`ST_BUSY_BIT] === 1'b0)
				break;
		end
		if (k == 100) begin
			error_cnt++;
			close_out();
		end
	endtask

	task automatic send(input logic [7:0] b, input logic ack);
		op(2'h2, b, 1'b0);
		`CHK(st[`ST_NACK_BIT], ~ack)
	endtask

	task automatic stop();
		op(2'h1, 8'h00, 1'b0);
		ptr = 3'h0;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input int n);
		logic hit;
		hit = (a == own) || (a == `BCAST_ADDR);
		op(2'h0, 8'h00, 1'b0);
		send({a, 1'b0}, hit);
		if (hit) begin
			send(cmd, 1'b1);
			ptr = cmd[2:0];
			for (int i = 0; i < n; i++) begin
				hit = mem[6][`PAGE_EN_BIT] || i < 2;
				send(wbuf[i], hit);
				if (hit && ptr == `PTR_CTRL)
					mem[6] = wbuf[i] & `CTRL_WMASK;
				else if (hit && ptr < `PTR_CTRL && mem[6][`TEST_WE_BIT])
					mem[ptr] = ptr[0] ? {wbuf[i][7:4], 4'h0} : wbuf[i];
				ptr = (ptr >= `PTR_LAST) ? 3'h0 : ptr + 3'h1;
			end
		end
		stop();
	endtask

	task automatic rd(input logic [6:0] a, input int cmd, input int n);
		logic [7:0] e;
		op(2'h0, 8'h00, 1'b0);
		if (cmd >= 0) begin
			send({a, 1'b0}, 1'b1);
			send(8'(cmd), 1'b1);
			ptr = 3'(cmd);
			op(2'h0, 8'h00, 1'b0);
		end
		send({a, 1'b1}, a == own);
		for (int i = 0; i < n; i++) begin
			op(2'h3, 8'hFF, i == n - 1);
			e = (!mem[6][`PAGE_EN_BIT] && i >= 2) ? 8'hFF : (ptr == `PTR_RSVD ? 8'h00 : mem[ptr]);
			`CHK(st[`ST_DATA_LSB +: 8], e)
			ptr = (ptr >= `PTR_LAST) ? 3'h0 : ptr + 3'h1;
		end
		stop();
	endtask

	task automatic fill(input int n);
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			wbuf[i] = rnd[7:0];
		end
	endtask

	// ==========================================
	// Main sequence
	initial begin
		own = {`ADDR_TOP, 4'hF};
		do_reset();
		`CHK(mode_o, `CTRL_RESET)
		// Controller offsets outside its two registers answer with an error and zero data
		apb(1'b0, 12'h008, 32'h0, st);
		`CHK(pslverr, 1'b1)
		`CHK(st, 32'h0)
		apb(1'b0, `APB_STATUS, 32'h0, st);
		`CHK(pslverr, 1'b0)
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			m[i] = rnd[11:0];
			mem[2 * i] = m[i][11:4];
			mem[2 * i + 1] = {m[i][3:0], 4'h0};
		end
		cur <= m[0];
		volt <= m[1];
		aux <= m[2];
		meas_valid <= 1'b1;
		tick(1);
		meas_valid <= 1'b0;
		tick(1);
		rd(own, 0, 8);
		for (int i = 0; i < 9; i++) begin
			hi_pin <= hi_tab[i];
			lo_pin <= lo_tab[i];
			own = {`ADDR_TOP, 4'(7 + i)};
			tick(4);
			wbuf[0] = `CTRL_RESET;
			wr(own, 8'h06, 1);
			wr({`ADDR_TOP, 4'((i == 8) ? 7 : 8 + i)}, 8'h06, 1);
		end
		wr({3'h7, own[3:0]}, 8'h06, 1);
		fill(2);
		wr(own, 8'hF9, 2);
		rd(own, 8'hF9, 2);
		wbuf[0] = 8'hFF;
		wr(own, 8'h06, 1);
		`CHK(mode_o, mem[6])
		fill(5);
		wbuf[2] = 8'h1F;
		wr(own, 8'h04, 5);
		fill(2);
		wr(own, 8'h07, 2);
		rd(own, 5, 4);
		rd(own, 7, 2);
		rd(own, -1, 2);
		wbuf[0] = 8'h10;
		wr(own, 8'h06, 1);
		fill(3);
		wr(own, 8'h00, 3);
		rd(own, 0, 3);
		wbuf[0] = 8'h1C;
		wr(`BCAST_ADDR, 8'h06, 1);
		`CHK(mode_o, 8'h1C)
		rd(`BCAST_ADDR, -1, 0);
		// Clock held low past the limit drops the engine back to idle
		op(2'h0, 8'h00, 1'b0);
		send({own, 1'b0}, 1'b1);
		tick(700);
		send(8'h06, 1'b0);
		stop();
		wbuf[0] = 8'h18;
		wr(own, 8'h06, 1);
		op(2'h0, 8'h00, 1'b0);
		send({own, 1'b0}, 1'b1);
		tick(700);
		send(8'h06, 1'b1);
		send(8'h1C, 1'b1);
		stop();
		`CHK(mode_o, 8'h1C)
		// Enable dropped at a random point of an address byte: both ends must hold still
		op(2'h0, 8'h00, 1'b0);
		apb(1'b1, `APB_CMD, {16'h0, own, 1'b0, 5'h0, 1'b0, 2'h2}, st);
		rnd = lfsr(rnd);
		tick(20 + int'(rnd[5:0]));
		ce <= 1'b0;
		tick(1);
		frz = {link.scl, link.sda, mode_o};
		tick(50);
		`CHK({link.scl, link.sda, mode_o}, frz)
		ce <= 1'b1;
		wait_idle();
		`CHK(st[`ST_NACK_BIT], 1'b0)
		stop();
		do_reset();
		`CHK(mode_o, `CTRL_RESET)
		rd(own, 0, 2);
		close_out();
	end
endmodule

`default_nettype wire
